//--- acss_slave.v
/*
  audio control serial slave: two-wire bus slave that takes a device
  address, a subaddress and data bytes into eight setting registers and
  returns a soft-mute status byte on reads; decodes the settings into
  the control fields that steer the audio path.
  assumes scl, sda and the mute pin are asynchronous pins with external
  pull-ups; sys_clk (20 MHz) is far faster than the 500 kbit/s bus.
*/
// Notes on behaviour
// - start is data falling while clock high
// - stop is data rising while clock high
// - data changes only while clock is low
// - eight bits msb first, then ack pulse
// - addressed slave holds data low during ack
// - answer only to address 1000101, lsb read/write
// - write: start, address, subaddress, data, stop
// - subaddress bit 4 auto-increments, bits 2:0 select
// - indices map to the eight setting registers
// - works up to 500 kbit/s
// - read sends status, bit 2 soft mute
// - status byte reloaded after every ack
// - gain bits 3:0, one dB per code
// - bits 5:4 choose aux2 output source
// - mute bits: slope, soft mute, aux1 mute
// - low mute pin forces soft mute
// - attenuation is fine plus coarse steps
// - coarse codes above nine mute speaker
// - highpass bit 3 picks order, 2:0 cutoff
// - flat mode forces fixed low cutoff
`timescale 1ns/10ps
`include "acss_map.vh"

module acss_slave
(
  input wire sys_clk,
  input wire rst_n,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire mute_pin_n,
  output reg [3:0] aux1_gain_db,
  output reg [1:0] aux2_source,
  output reg aux2_muted,
  output reg soft_mute_fast,
  output reg soft_mute_active,
  output reg aux1_input_mute,
  output reg [3:0] left_coarse,
  output reg [2:0] left_fine,
  output reg left_muted,
  output reg [3:0] right_coarse,
  output reg [2:0] right_fine,
  output reg right_muted,
  output reg [3:0] front_left_cut,
  output reg front_left_flat,
  output reg [3:0] front_right_cut,
  output reg front_right_flat,
  output reg [3:0] rear_left_cut,
  output reg rear_left_flat,
  output reg [3:0] rear_right_cut,
  output reg rear_right_flat
);

  // protocol states
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_SUB = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_READ = 3'h4;
  localparam ST_ACK = 3'h5;
  localparam ST_MACK = 3'h6;
  localparam ST_SKIP = 3'h7;

  // two-stage synchronisers, first stage read only by second
  reg scl_s1_reg;
  reg scl_s2_reg;
  reg sda_s1_reg;
  reg sda_s2_reg;
  reg mute_s1_reg;
  reg mute_s2_reg;
  // previous synced samples for edge finding
  reg scl_d_reg;
  reg sda_d_reg;

  // protocol state
  reg [2:0] state_reg;
  reg [2:0] ret_reg; // state to enter after ack slot
  reg [2:0] bit_reg; // bit counter within byte
  reg [7:0] shift_reg; // receive / transmit shifter
  reg [2:0] idx_reg; // target register index
  reg ainc_reg; // auto-increment flag
  reg wr_pend_reg; // data byte awaits commit after ack
  reg drive_low_reg; // slave pulls sda low
  // all eight bits of a byte are in; without it the clock fall that
  // closes a start would look like the end of a byte
  reg full_reg;

  // setting registers
  reg [7:0] regs [0:7];
  // one name per setting register, so the decode lines stay short
  wire [7:0] set_gain = regs[`ACSS_IDX_GAIN_SEL];
  wire [7:0] set_mute = regs[`ACSS_IDX_MUTE];
  wire [7:0] set_left = regs[`ACSS_IDX_SPK_L];
  wire [7:0] set_right = regs[`ACSS_IDX_SPK_R];
  wire [7:0] set_front_left = regs[`ACSS_IDX_FRONT_LEFT];
  wire [7:0] set_front_right = regs[`ACSS_IDX_FRONT_RIGHT];
  wire [7:0] set_rear_left = regs[`ACSS_IDX_REAR_LEFT];
  wire [7:0] set_rear_right = regs[`ACSS_IDX_REAR_RIGHT];

  // decoded edges and conditions
  wire scl_rise = scl_s2_reg & ~scl_d_reg;
  wire scl_fall = ~scl_s2_reg & scl_d_reg;
  wire start_cond = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  wire stop_cond = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

  // soft mute from register (0 = on) or from the pin
  wire soft_mute_from_reg = ~set_mute[`ACSS_MUTE_SOFT_BIT];
  wire soft_mute_now = soft_mute_from_reg | ~mute_s2_reg;

  // status byte, only the soft mute bit is live
  wire [7:0] status_byte = {7'h00, soft_mute_now} <<
                           `ACSS_STAT_SOFT_MUTE_BIT;

  // open-drain: only ever drive low
  assign sda_out = 1'b0;
  assign sda_oe = drive_low_reg;

  // synchronisers and edge history
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      mute_s1_reg <= 1'b1;
      mute_s2_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      mute_s1_reg <= mute_pin_n;
      mute_s2_reg <= mute_s1_reg;
      scl_d_reg <= scl_s2_reg;
      sda_d_reg <= sda_s2_reg;
    end
  end

  // protocol engine; data sampled on clock rise, driven on clock fall
  // so the line is steady while clock is high
  integer i;
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      ret_reg <= ST_IDLE;
      bit_reg <= `ACSS_BIT_ZERO;
      shift_reg <= 8'h00;
      idx_reg <= `ACSS_IDX_FIRST;
      ainc_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      drive_low_reg <= 1'b0;
      full_reg <= 1'b0;
      for (i = 0; i < 8; i = i + 1)
        regs[i] <= `ACSS_REG_RST;
    end
    else if (stop_cond)
    begin
      // stop ends any transfer and releases the line
      state_reg <= ST_IDLE;
      full_reg <= 1'b0;
      drive_low_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
    end
    else if (start_cond)
    begin
      // a start mid-transfer also resyncs, though masters must stop first
      state_reg <= ST_ADDR;
      full_reg <= 1'b0;
      bit_reg <= `ACSS_BIT_ZERO;
      drive_low_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          drive_low_reg <= 1'b0;
        end
        ST_ADDR, ST_SUB, ST_DATA, ST_SKIP:
        begin
          // receive eight bits msb first
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_s2_reg};
            bit_reg <= bit_reg + 3'h1;
            // eighth rise: the byte is whole
            if (bit_reg == `ACSS_BIT_LAST)
              full_reg <= 1'b1;
          end
          else if (scl_fall && full_reg && state_reg != ST_SKIP)
          begin
            // eighth bit done: decide whether to acknowledge
            full_reg <= 1'b0;
            case (state_reg)
              ST_ADDR:
              begin
                if (shift_reg[7:1] == `ACSS_DEV_ADDR)
                begin
                  drive_low_reg <= 1'b1;
                  ret_reg <= shift_reg[0] ? ST_READ : ST_SUB;
                  state_reg <= ST_ACK;
                end
                else
                  state_reg <= ST_IDLE;
              end
              ST_SUB:
              begin
                ainc_reg <= shift_reg[`ACSS_SUB_AINC_BIT];
                idx_reg <= shift_reg[`ACSS_SUB_IDX_HI:`ACSS_SUB_IDX_LO];
                drive_low_reg <= 1'b1;
                ret_reg <= ST_DATA;
                state_reg <= ST_ACK;
              end
              default:
              begin
                wr_pend_reg <= 1'b1;
                drive_low_reg <= 1'b1;
                ret_reg <= ST_DATA;
                state_reg <= ST_ACK;
              end
            endcase
          end
        end
        ST_ACK:
        begin
          // hold low through the whole ninth pulse, release on its fall
          if (scl_fall)
          begin
            drive_low_reg <= 1'b0;
            bit_reg <= `ACSS_BIT_ZERO;
            if (wr_pend_reg)
            begin
              regs[idx_reg] <= shift_reg;
              wr_pend_reg <= 1'b0;
              if (ainc_reg)
                idx_reg <= idx_reg + 3'h1;
            end
            if (ret_reg == ST_READ)
            begin
              // load status and put msb out right away
              shift_reg <= {status_byte[6:0], 1'b0};
              drive_low_reg <= ~status_byte[7];
              state_reg <= ST_READ;
            end
            else
              state_reg <= ret_reg;
          end
        end
        ST_READ:
        begin
          // shift status out, change only on clock fall
          if (scl_rise)
            bit_reg <= bit_reg + 3'h1;
          else if (scl_fall)
          begin
            if (bit_reg == `ACSS_BIT_ZERO)
            begin
              drive_low_reg <= 1'b0; // master acks
              state_reg <= ST_MACK;
            end
            else
            begin
              drive_low_reg <= ~shift_reg[7];
              shift_reg <= {shift_reg[6:0], 1'b0};
            end
          end
        end
        ST_MACK:
        begin
          // master ack slot; nack leaves line free until stop
          if (scl_rise)
          begin
            if (sda_s2_reg)
              state_reg <= ST_SKIP;
          end
          else if (scl_fall)
          begin
            shift_reg <= {status_byte[6:0], 1'b0};
            drive_low_reg <= ~status_byte[7];
            bit_reg <= `ACSS_BIT_ZERO;
            state_reg <= ST_READ;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // decode settings into control fields
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      aux1_gain_db <= 4'h0;
      aux2_source <= 2'h0;
      aux2_muted <= 1'b0;
      soft_mute_fast <= 1'b0;
      soft_mute_active <= 1'b0;
      aux1_input_mute <= 1'b0;
      left_coarse <= 4'h0;
      left_fine <= 3'h0;
      left_muted <= 1'b0;
      right_coarse <= 4'h0;
      right_fine <= 3'h0;
      right_muted <= 1'b0;
      front_left_cut <= 4'h0;
      front_left_flat <= 1'b0;
      front_right_cut <= 4'h0;
      front_right_flat <= 1'b0;
      rear_left_cut <= 4'h0;
      rear_left_flat <= 1'b0;
      rear_right_cut <= 4'h0;
      rear_right_flat <= 1'b0;
    end
    else
    begin
      aux1_gain_db <= set_gain[`ACSS_GAIN_HI:`ACSS_GAIN_LO];
      aux2_source <= set_gain[`ACSS_AUX2_HI:`ACSS_AUX2_LO];
      aux2_muted <= set_gain[`ACSS_AUX2_HI:`ACSS_AUX2_LO] ==
                    `ACSS_AUX2_MUTED;
      soft_mute_fast <= set_mute[`ACSS_MUTE_SLOPE_BIT];
      soft_mute_active <= soft_mute_now;
      aux1_input_mute <= ~set_mute[`ACSS_MUTE_AUX1_BIT];
      left_fine <= set_left[`ACSS_SPK_FINE_HI:`ACSS_SPK_FINE_LO];
      left_coarse <= set_left[`ACSS_SPK_COARSE_HI:`ACSS_SPK_COARSE_LO];
      left_muted <= set_left[`ACSS_SPK_COARSE_HI:`ACSS_SPK_COARSE_LO] >
                    `ACSS_SPK_COARSE_MAX;
      right_fine <= set_right[`ACSS_SPK_FINE_HI:`ACSS_SPK_FINE_LO];
      right_coarse <= set_right[`ACSS_SPK_COARSE_HI:`ACSS_SPK_COARSE_LO];
      right_muted <= set_right[`ACSS_SPK_COARSE_HI:`ACSS_SPK_COARSE_LO] >
                     `ACSS_SPK_COARSE_MAX;
      // cut code: bit 3 = flat, low bits forced in flat mode
      front_left_flat <= set_front_left[`ACSS_HIGHPASS_FLAT_BIT];
      front_left_cut <= highpass_cut(set_front_left);
      front_right_flat <= set_front_right[`ACSS_HIGHPASS_FLAT_BIT];
      front_right_cut <= highpass_cut(set_front_right);
      rear_left_flat <= set_rear_left[`ACSS_HIGHPASS_FLAT_BIT];
      rear_left_cut <= highpass_cut(set_rear_left);
      rear_right_flat <= set_rear_right[`ACSS_HIGHPASS_FLAT_BIT];
      rear_right_cut <= highpass_cut(set_rear_right);
    end
  end

  // highpass cutoff code; flat mode ignores the cutoff bits
  // the fixed low cutoff of flat mode gets its own code, so a user
  // cannot mistake it for any second-order setting
  function [3:0] highpass_cut;
    input [7:0] v;
    begin
      if (v[`ACSS_HIGHPASS_FLAT_BIT])
        highpass_cut = {1'b1, `ACSS_HIGHPASS_CUT_FLAT};
      else
        highpass_cut = {1'b0, v[`ACSS_HIGHPASS_CUT_HI:`ACSS_HIGHPASS_CUT_LO]};
    end
  endfunction

endmodule

//--- acss_map.vh
/*
  constants for the audio control serial slave: bus address, subaddress
  and data field positions, register indices, status bit, bit counter limits.
  assumes it is included by its bare name from the design file.
*/
`ifndef ACSS_MAP_VH
`define ACSS_MAP_VH

// 7-bit device address on the serial bus
`define ACSS_DEV_ADDR 7'h45
// subaddress fields
`define ACSS_SUB_AINC_BIT 4
`define ACSS_SUB_IDX_HI 2
`define ACSS_SUB_IDX_LO 0
// register indices
`define ACSS_IDX_GAIN_SEL 3'h0
`define ACSS_IDX_MUTE 3'h1
`define ACSS_IDX_SPK_L 3'h2
`define ACSS_IDX_SPK_R 3'h3
`define ACSS_IDX_FRONT_LEFT 3'h4
`define ACSS_IDX_FRONT_RIGHT 3'h5
`define ACSS_IDX_REAR_LEFT 3'h6
`define ACSS_IDX_REAR_RIGHT 3'h7
`define ACSS_IDX_LAST 3'h7
`define ACSS_IDX_FIRST 3'h0
// reset value for every setting register (none documented)
`define ACSS_REG_RST 8'h00
// gain and select fields
`define ACSS_GAIN_HI 3
`define ACSS_GAIN_LO 0
`define ACSS_AUX2_HI 5
`define ACSS_AUX2_LO 4
`define ACSS_AUX2_MUTED 2'h3
// mute register fields
`define ACSS_MUTE_SLOPE_BIT 0
`define ACSS_MUTE_SOFT_BIT 1
`define ACSS_MUTE_AUX1_BIT 2
// speaker attenuator fields
`define ACSS_SPK_FINE_HI 2
`define ACSS_SPK_FINE_LO 0
`define ACSS_SPK_COARSE_HI 6
`define ACSS_SPK_COARSE_LO 3
`define ACSS_SPK_COARSE_MAX 4'h9
// highpass fields
`define ACSS_HIGHPASS_FLAT_BIT 3
`define ACSS_HIGHPASS_CUT_HI 2
`define ACSS_HIGHPASS_CUT_LO 0
`define ACSS_HIGHPASS_CUT_FLAT 3'h0
// status byte: soft mute flag position
`define ACSS_STAT_SOFT_MUTE_BIT 2
// bit counter limits
`define ACSS_BIT_LAST 3'h7
`define ACSS_BIT_ZERO 3'h0
`endif

//--- acss_bus_master.sv
/*
  bus master model for the audio control serial slave: drives the bus
  clock and pulls the data line low, one 400 ns bit at a time.
  assumes an open-drain data wire with a pull-up, resolved by the bench.
*/
`timescale 1ns/10ps
module acss_bus_master
(
  input wire sys_clk,
  output logic scl,
  output logic sda_low,
  input wire sda_w
);
  // idle bus: clock high and still, data released
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // n rising edges; two of them are a quarter bit
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // data falls while clock high; every frame but the first opens after a stop
  task start_bit();
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(4);
  endtask
  // data rises while clock high; also used to abort on a missing ack
  task stop_bit();
    sda_low <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask
  // data moves only in the low phase; a 1 releases the wire
  task bit_io(input logic b, output logic r);
    sda_low <= ~b;
    tick(2);
    scl <= 1'b1;
    tick(4);
    r = sda_w;
    scl <= 1'b0;
    tick(2);
  endtask
  // eight bits, msb first, returns what the wire carried
  task byte_io(input logic [7:0] d, output logic [7:0] r);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], b);
      r[i] = b;
    end
  endtask
endmodule

//--- acss_slave_properties.sv
/*
  timing and decode checks for the audio control serial slave.
  assumes it is bound to the slave and sees only its ports.
*/
`timescale 1ns/10ps
module acss_slave_properties
(
  input wire sys_clk,
  input wire rst_n,
  input wire scl_in,
  input wire sda_out,
  input wire sda_oe,
  input wire mute_pin_n,
  input wire soft_mute_active,
  input wire [1:0] aux2_source,
  input wire aux2_muted,
  input wire [3:0] left_coarse,
  input wire left_muted,
  input wire [3:0] right_coarse,
  input wire right_muted,
  input wire [3:0] front_left_cut,
  input wire front_left_flat,
  input wire [3:0] rear_right_cut,
  input wire rear_right_flat
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // pin low long enough to cross the synchroniser
  sequence pin_low;
    !mute_pin_n [*4];
  endsequence
  // bus clock rising while the slave pulls the wire
  sequence pull_at_rise;
    sda_oe && scl_in && !$past(scl_in);
  endsequence
  chk_pin_mute: assert property (pin_low |=> soft_mute_active)
    else $error("soft mute missing while mute pin low");
  chk_ack_hold: assert property (pull_at_rise |-> sda_oe [*3])
    else $error("slave let go of data during clock high");
  // one cycle of slack after the rise covers synchroniser lag
  chk_drive_stable: assert property
    (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("slave data changed while clock high");
  // a pull may only begin in the low phase of the bus clock
  chk_pull_low: assert property
    ($rose(sda_oe) |-> !scl_in && !sda_out)
    else $error("slave pull began while clock high");
  chk_aux2_mute: assert property
    (aux2_muted == (aux2_source == 2'h3))
    else $error("aux2 mute disagrees with source code");
  chk_spk_mute: assert property ((left_muted == (left_coarse > 4'h9))
    && (right_muted == (right_coarse > 4'h9)))
    else $error("speaker mute disagrees with coarse code");
  chk_flat_cut: assert property (front_left_flat |->
    front_left_cut == 4'h8)
    else $error("flat mode cutoff wrong");
  chk_order_cut: assert property (!rear_right_flat |->
    !rear_right_cut[3])
    else $error("second order cutoff code wrong");
endmodule
bind acss_slave acss_slave_properties i_chk
(
  .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .mute_pin_n(mute_pin_n),
  .soft_mute_active(soft_mute_active), .aux2_source(aux2_source),
  .aux2_muted(aux2_muted), .left_coarse(left_coarse),
  .left_muted(left_muted), .right_coarse(right_coarse),
  .right_muted(right_muted), .front_left_cut(front_left_cut),
  .front_left_flat(front_left_flat), .rear_right_cut(rear_right_cut),
  .rear_right_flat(rear_right_flat)
);

//--- acss_slave_tb.sv
/*
  self-checking bench for the audio control serial slave: random and
  corner writes, refused addresses, status reads with the mute pin.
  assumes the slave design and the bus master model are compiled first.
*/
`timescale 1ns/10ps
module acss_slave_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic mute_pin_n = 1'b1;
  wire scl, sda_low, sda_w, sda_out, sda_oe;
  wire [3:0] gain, lc, rc, flc, frc, rlc, rrc;
  wire [2:0] lf, rf;
  wire [1:0] src;
  wire a2m, smf, sma, a1m, lm, rm, flf, frf, rlf, rrf;
  logic [7:0] regs [8]; // expected setting registers
  logic [7:0] rd;
  logic [7:0] bad [4] = '{8'h8c, 8'h88, 8'h0a, 8'h8d};
  logic ack;
  integer seed = 32'h3289;
  int failures = 0;
  int checked = 0;
  always #25 sys_clk = ~sys_clk;
  // open drain with pull-up: low whenever either side pulls
  assign sda_w = ~(sda_low | (sda_oe & ~sda_out));
  acss_bus_master i_mst
  (
    .sys_clk(sys_clk), .scl(scl), .sda_low(sda_low), .sda_w(sda_w)
  );
  acss_slave i_dut
  (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .mute_pin_n(mute_pin_n),
    .aux1_gain_db(gain), .aux2_source(src), .aux2_muted(a2m),
    .soft_mute_fast(smf), .soft_mute_active(sma), .aux1_input_mute(a1m),
    .left_coarse(lc), .left_fine(lf), .left_muted(lm),
    .right_coarse(rc), .right_fine(rf), .right_muted(rm),
    .front_left_cut(flc), .front_left_flat(flf),
    .front_right_cut(frc), .front_right_flat(frf),
    .rear_left_cut(rlc), .rear_left_flat(rlf),
    .rear_right_cut(rrc), .rear_right_flat(rrf)
  );
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim();
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // expected cutoff code: flat mode overrides the cutoff bits
  function logic [7:0] cut(input logic [7:0] v);
    return v[3] ? 8'h08 : {5'h0, v[2:0]};
  endfunction
  // every decoded field against the expected registers
  task check_regs();
    i_mst.tick(4);
    // look half a cycle after the edge so nothing launched there races
    @(negedge sys_clk);
    check(8'(gain), 8'(regs[0][3:0]));
    check(8'(src), 8'(regs[0][5:4]));
    check(8'(a2m), 8'(regs[0][5:4] == 2'h3));
    check(8'(smf), 8'(regs[1][0]));
    check(8'(sma), 8'(!regs[1][1] | !mute_pin_n));
    check(8'(a1m), 8'(!regs[1][2]));
    check({lc, 1'b0, lf}, {regs[2][6:3], 1'b0, regs[2][2:0]});
    check({rc, 1'b0, rf}, {regs[3][6:3], 1'b0, regs[3][2:0]});
    check({6'h0, lm, rm},
      {6'h0, regs[2][6:3] > 4'h9, regs[3][6:3] > 4'h9});
    check({flf, frf, rlf, rrf, 4'h0},
      {regs[4][3], regs[5][3], regs[6][3], regs[7][3], 4'h0});
    check(8'(flc), cut(regs[4]));
    check(8'(frc), cut(regs[5]));
    check(8'(rlc), cut(regs[6]));
    check(8'(rrc), cut(regs[7]));
    // back onto the rising edge before any pin is driven again
    @(posedge sys_clk);
  endtask
  // write n random bytes, forced bits or-ed in for corner codes
  task wr(input logic [7:0] sub, input int n, input logic [7:0] orm);
    logic [2:0] idx;
    logic [7:0] d;
    idx = sub[2:0];
    i_mst.start_bit();
    i_mst.byte_io({7'h45, 1'b0}, rd);
    i_mst.bit_io(1'b1, ack);
    check(8'(ack), 8'h00);
    i_mst.byte_io(sub, rd);
    i_mst.bit_io(1'b1, ack);
    check(8'(ack), 8'h00);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($random(seed)) | orm;
      i_mst.byte_io(d, rd);
      i_mst.bit_io(1'b1, ack);
      check(8'(ack), 8'h00);
      regs[idx] = d;
      if (sub[4]) idx = idx + 3'h1;
    end
    i_mst.stop_bit();
    check_regs();
  endtask
  // a hang counts as a mismatch
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    end_sim();
  end
  initial
  begin
    for (int i = 0; i < 8; i++) regs[i] = 8'h00;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    i_mst.tick(6);
    check(8'(sda_oe), 8'h00);
    check_regs();
    wr(8'h17, 9, 8'h00);
    wr(8'he2, 3, 8'h78);
    wr(8'h04, 2, 8'h08);
    wr(8'h11, 1, 8'h02);
    // foreign addresses and reads: no ack, master aborts
    for (int i = 0; i < 4; i++)
    begin
      i_mst.start_bit();
      i_mst.byte_io(bad[i], rd);
      i_mst.bit_io(1'b1, ack);
      check(8'(ack), 8'h01);
      i_mst.byte_io(8'h00, rd);
      i_mst.bit_io(1'b1, ack);
      check(8'(ack), 8'h01);
      i_mst.stop_bit();
    end
    check_regs();
    // status read, pin pulled low before the ack reloads the byte
    i_mst.start_bit();
    i_mst.byte_io({7'h45, 1'b1}, rd);
    i_mst.bit_io(1'b1, ack);
    check(8'(ack), 8'h00);
    i_mst.byte_io(8'hff, rd);
    check(8'(rd[2]), 8'h00);
    mute_pin_n <= 1'b0;
    i_mst.tick(6);
    i_mst.bit_io(1'b0, ack);
    i_mst.byte_io(8'hff, rd);
    check(8'(rd[2]), 8'h01);
    i_mst.bit_io(1'b1, ack);
    i_mst.stop_bit();
    check_regs();
    mute_pin_n <= 1'b1;
    check_regs();
    end_sim();
  end
endmodule
